//--- core/ssc_core.sv
// Serial port control and status with AXI4-Lite register access
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module ssc_core #(
  parameter int WORD_BITS = 8,
  parameter int CLK_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire ssc_pkg::ssc_pins_t pins_in,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic bclk_out,
  output logic xmit_irq_ok,
  output logic xmit_irq_exc,
  output logic rcv_irq_ok,
  output logic rcv_irq_exc
);
  import ssc_pkg::*;

  localparam int CW = (WORD_BITS > 1) ? $clog2(WORD_BITS) : 1;
  localparam int DW = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam logic [CW-1:0] LAST_IDX = CW'(WORD_BITS - 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  logic [CTRL_W-1:0] ctrl;
  logic [1:0] prst_reg;
  ssc_stat_t stat;
  logic tue_arm, roe_arm, ien_x, ien_r;

  // Input synchronisers with agreement filter
  ssc_pins_t s1, s2, s3, pin;
  logic bclk_q, fs_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin <= '0;
    end else begin
      s1 <= pins_in;
      s2 <= s1;
      s3 <= s2;
      pin <= (s2 & s3) | (pin & (s2 ^ s3));
    end
  end

  wire prst = prst_reg[PR_PORT] | prst_reg[PR_STOP];
  wire rst_all = !aresetn | prst;
  wire net = ctrl[CB_NET];
  wire rise = pin.bclk & !bclk_q;
  wire fall = !pin.bclk & bclk_q;

  // Frame sync only from the pin; none is made here
  wire frame_start = rise & (ctrl[CB_FSL_HI] ? fs_q :
    (pin.fsync & !fs_q));

  // Slot and bit timing
  logic [CW-1:0] cnt;
  logic in_slot;
  wire in_bit = frame_start | (rise & in_slot);
  wire [CW-1:0] bit_idx = frame_start ? '0 : cnt;
  wire last_bit = bit_idx == LAST_IDX;
  wire slot_begin = in_bit & (bit_idx == '0);
  wire word_end = in_bit & last_bit;
  wire [CW-1:0] next_cnt = last_bit ? '0 : bit_idx + CW'(1);

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      cnt <= '0;
      in_slot <= 1'b0;
      fs_q <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= pin.bclk;
      if (rise)
        fs_q <= pin.fsync;
      if (in_bit) begin
        cnt <= next_cnt;
        in_slot <= !(last_bit & !net);
      end
    end
  end

  // Bus slave handshake
  logic aw_got, w_got;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire next_aw_got = aw_got | aw_hs;
  wire next_w_got = w_got | w_hs;
  wire wr_fire = aw_got & w_got & !bvalid;
  wire next_bvalid = wr_fire | (bvalid & !bready);
  wire next_rvalid = ar_hs | (rvalid & !rready);

  wire wr_ctrl = wr_fire & hit(wa, ADDR_CTRL);
  wire wr_xmit = wr_fire & hit(wa, ADDR_XMIT);
  wire wr_null = wr_fire & hit(wa, ADDR_NULL);
  wire wr_prst = wr_fire & hit(wa, ADDR_PRST);
  wire wr_tx = wr_xmit | wr_null;
  wire wr_ok = wr_ctrl | wr_tx | wr_prst | hit(wa, ADDR_STAT)
    | hit(wa, ADDR_RCV);
  wire rd_stat = ar_hs & hit(araddr, ADDR_STAT);
  wire rd_rcv = ar_hs & hit(araddr, ADDR_RCV);
  wire rd_ok = hit(araddr, ADDR_CTRL) | hit(araddr, ADDR_STAT)
    | hit(araddr, ADDR_RCV) | hit(araddr, ADDR_XMIT)
    | hit(araddr, ADDR_NULL) | hit(araddr, ADDR_PRST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= '0;
      wd <= '0;
      ws <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (aw_hs)
        wa <= awaddr;
      if (w_hs) begin
        wd <= wdata;
        ws <= wstrb;
      end
      aw_got <= next_aw_got & !wr_fire;
      w_got <= next_w_got & !wr_fire;
      awready <= !next_aw_got & !next_bvalid;
      wready <= !next_w_got & !next_bvalid;
      bvalid <= next_bvalid;
      if (wr_fire)
        bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
    end
  end

  // Control and port reset registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      prst_reg <= '0;
    end else begin
      if (wr_ctrl && ws[0])
        ctrl[7:0] <= wd[7:0];
      if (wr_ctrl && ws[1])
        ctrl[15:8] <= wd[15:8];
      if (wr_prst && ws[0])
        prst_reg <= wd[1:0];
    end
  end

  // Transmit path
  logic [WORD_BITS-1:0] hold, tx_sh;
  logic hold_null, xmit_act;
  wire x_go = ctrl[CB_XON] & (frame_start | xmit_act);
  wire x_xfer = slot_begin & x_go & !stat.xmit_hold_empty;
  wire x_under = slot_begin & x_go & stat.xmit_hold_empty;

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      hold <= '0;
      hold_null <= 1'b0;
    end else if (wr_xmit) begin
      hold <= wd[WORD_BITS-1:0];
      hold_null <= 1'b0;
    end else if (wr_null) begin
      hold_null <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      xmit_act <= 1'b0;
      tx_sh <= '0;
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe <= 1'b0;
    end else if (slot_begin) begin
      xmit_act <= x_go;
      serial_out_pin_oe <= x_go & !hold_null;
      serial_out_pin_o <= hold[WORD_BITS-1];
      tx_sh <= hold << 1;
    end else if (in_bit) begin
      serial_out_pin_o <= tx_sh[WORD_BITS-1];
      tx_sh <= tx_sh << 1;
    end else if (fall && !in_slot) begin
      serial_out_pin_oe <= 1'b0;
    end
  end

  // Receive path
  logic [WORD_BITS-1:0] rx_sh, rx_hold;
  logic rcv_act, rx_busy, p0, p1, rfs_w;
  wire [WORD_BITS-1:0] next_rx = {rx_sh[WORD_BITS-2:0], pin.rxd};
  wire r_go = ctrl[CB_RON] & (frame_start | rcv_act);
  wire r_done = word_end & rx_busy;
  wire r_xfer = r_done & !stat.rcv_hold_full;
  wire r_over = r_done & stat.rcv_hold_full;

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      rcv_act <= 1'b0;
      rx_busy <= 1'b0;
      p0 <= 1'b0;
      p1 <= 1'b0;
      rfs_w <= 1'b0;
      rx_sh <= '0;
    end else begin
      if (in_bit)
        rx_sh <= next_rx;
      if (slot_begin) begin
        rcv_act <= r_go;
        rx_busy <= r_go;
        p0 <= pin.ctrl0;
        p1 <= pin.ctrl1;
        rfs_w <= frame_start;
      end else if (word_end) begin
        rx_busy <= 1'b0;
      end
    end
  end

  // Status flags; a hardware set wins over a software clear
  wire next_tde = x_xfer | (stat.xmit_hold_empty & !wr_tx);
  wire next_tue = x_under | (stat.xmit_underrun & !(tue_arm & wr_tx));
  wire next_rdf = r_xfer | (stat.rcv_hold_full & !rd_rcv);
  wire next_roe = r_over | (stat.rcv_overrun_flag & !(roe_arm & rd_rcv));

  always_ff @(posedge aclk) begin
    if (rst_all) begin
      stat <= STAT_RST;
      rx_hold <= '0;
      tue_arm <= 1'b0;
      roe_arm <= 1'b0;
    end else begin
      stat.xmit_hold_empty <= next_tde;
      stat.xmit_underrun <= next_tue;
      stat.rcv_hold_full <= next_rdf;
      stat.rcv_overrun_flag <= next_roe;
      tue_arm <= next_tue & (tue_arm | (rd_stat & stat.xmit_underrun));
      roe_arm <= next_roe & (roe_arm | (rd_stat & stat.rcv_overrun_flag));
      if (slot_begin)
        stat.xmit_frame_start_flag <= frame_start;
      if (r_xfer) begin
        rx_hold <= next_rx;
        stat.rcv_frame_start_flag <= rfs_w;
        stat.if0 <= p0;
        stat.if1 <= p1;
      end
    end
  end

  // Status as read, flags masked by pin direction and clock mode
  wire if0_on = !ctrl[CB_DIR0] & ctrl[CB_CCS];
  wire if1_on = !ctrl[CB_DIR1] & ctrl[CB_CCS];
  wire [7:0] stat_rd = {stat[7:2], stat.if1 & if1_on, stat.if0 & if0_on};
  wire [31:0] rd_mux =
    hit(araddr, ADDR_CTRL) ? {16'h0000, ctrl} :
    hit(araddr, ADDR_STAT) ? {24'h000000, stat_rd} :
    hit(araddr, ADDR_RCV) ? 32'(rx_hold) :
    hit(araddr, ADDR_PRST) ? {30'h00000000, prst_reg} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (ar_hs) begin
        rdata <= rd_mux;
        rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // Interrupt enables follow at frame sync in network mode
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      ien_x <= 1'b0;
      ien_r <= 1'b0;
      xmit_irq_ok <= 1'b0;
      xmit_irq_exc <= 1'b0;
      rcv_irq_ok <= 1'b0;
      rcv_irq_exc <= 1'b0;
    end else begin
      if (!net || frame_start) begin
        ien_x <= ctrl[CB_XIE];
        ien_r <= ctrl[CB_RIE];
      end
      xmit_irq_exc <= ien_x & stat.xmit_hold_empty & stat.xmit_underrun;
      xmit_irq_ok <= ien_x & stat.xmit_hold_empty & !stat.xmit_underrun;
      rcv_irq_exc <= ien_r & stat.rcv_hold_full & stat.rcv_overrun_flag;
      rcv_irq_ok <= ien_r & stat.rcv_hold_full & !stat.rcv_overrun_flag;
    end
  end

  // Bit clock out: free running, or gated to transmit words
  logic [DW-1:0] div;
  wire tick = div == DIV_LAST;
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      div <= '0;
      bclk_out <= 1'b0;
    end else begin
      div <= tick ? '0 : div + DW'(1);
      if (tick && (!ctrl[CB_GCK] || serial_out_pin_oe || bclk_out))
        bclk_out <= !bclk_out;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (rst_all);

  a_tde_write_clr: assert property (
    wr_tx && !x_xfer |=> !stat.xmit_hold_empty)
    else $error("empty flag not cleared by write");
  a_xirq_vector: assert property (
    ien_x && stat.xmit_hold_empty && stat.xmit_underrun |=> xmit_irq_exc && !xmit_irq_ok)
    else $error("transmit vector wrong");
  a_rirq_vector: assert property (
    ien_r && stat.rcv_hold_full && !stat.rcv_overrun_flag |=> rcv_irq_ok && !rcv_irq_exc)
    else $error("receive vector wrong");
  a_rdf_read_clr: assert property (
    rd_rcv && !r_xfer |=> !stat.rcv_hold_full)
    else $error("full flag not cleared by read");
  a_underrun_set: assert property (
    x_under && !wr_xmit |=> stat.xmit_underrun && $stable(hold))
    else $error("underrun not flagged");
  a_overrun_drop: assert property (
    r_over |=> stat.rcv_overrun_flag && $stable(rx_hold))
    else $error("overrun word transferred");
  a_stat_upper: assert property (
    rd_stat |=> rvalid && rdata[31:8] == 24'h000000)
    else $error("status upper bits not zero");
  a_net_float: assert property (
    slot_begin && !x_go |=> !serial_out_pin_oe [*2])
    else $error("output driven in disabled slot");
  a_tfs_track: assert property (
    slot_begin |=> stat.xmit_frame_start_flag == $past(frame_start))
    else $error("frame start flag wrong");
  a_flag_mask: assert property (
    rd_stat && (ctrl[CB_DIR0] || !ctrl[CB_CCS]) |=> !rdata[0])
    else $error("input flag not masked");
endmodule // ssc_core

//--- core/ssc_pkg.sv
// Shared constants and carrier types of the serial port control block
package ssc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_XMIT = 8'h08;
  localparam logic [7:0] ADDR_NULL = 8'h0c;
  localparam logic [7:0] ADDR_RCV = 8'h10;
  localparam logic [7:0] ADDR_PRST = 8'h14;
  // Control register bit positions
  localparam int CB_DIR0 = 2;
  localparam int CB_DIR1 = 3;
  localparam int CB_FSL_HI = 8;
  localparam int CB_CCS = 9;
  localparam int CB_GCK = 10;
  localparam int CB_NET = 11;
  localparam int CB_XON = 12;
  localparam int CB_RON = 13;
  localparam int CB_XIE = 14;
  localparam int CB_RIE = 15;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  // Port reset register bit positions
  localparam int PR_PORT = 0;
  localparam int PR_STOP = 1;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Serial pins as seen from outside
  typedef struct packed {
    logic bclk;
    logic fsync;
    logic rxd;
    logic ctrl0;
    logic ctrl1;
  } ssc_pins_t;
  // Status register, bit 7 down to bit 0
  typedef struct packed {
    logic rcv_hold_full;
    logic xmit_hold_empty;
    logic rcv_overrun_flag;
    logic xmit_underrun;
    logic rcv_frame_start_flag;
    logic xmit_frame_start_flag;
    logic if1;
    logic if0;
  } ssc_stat_t;
  localparam ssc_stat_t STAT_RST = 8'h40;
endpackage

//--- tb/ssc_codec.sv
// Serial codec model that frames words on the link
`timescale 1ns/1ps
module ssc_codec (
  input wire logic tx_d,
  input wire logic tx_oe,
  output ssc_pkg::ssc_pins_t pins
);
  import ssc_pkg::*;
  logic [7:0] got = 8'h00;
  logic oe_seen = 1'b0;
  // Bit clock stands low between frames
  initial pins = 5'h02;
  // One bit-wide sync frame, one word each way, MSB first
  task automatic frame(input logic [7:0] w, input logic c0, input logic c1);
    got = 8'h00;
    oe_seen = 1'b0;
    pins.ctrl0 = c0;
    pins.ctrl1 = c1;
    pins.fsync = 1'b1;
    #62.5 pins.bclk = 1'b1;
    #62.5 pins.bclk = 1'b0;
    pins.fsync = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pins.rxd = w[i];
      #62.5 pins.bclk = 1'b1;
      #62.5 got[i] = tx_oe ? tx_d : ~tx_d;
      oe_seen = oe_seen | tx_oe;
      pins.bclk = 1'b0;
    end
    // Released data line shows the inverse of the last bit
    pins.rxd = ~w[0];
  endtask
endmodule // ssc_codec

//--- tb/tb.sv
// Self-checking bench of the serial port control block
`timescale 1ns/1ps
module tb;
  import ssc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sd, sd_oe;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  wire [3:0] irqs;
  wire bco;
  ssc_pins_t pins;
  int bad_count = 0;
  int n_compared = 0;

  ssc_core #(.WORD_BITS(8), .CLK_DIV(4)) ssc_core_i (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pins_in(pins), .serial_out_pin_o(sd), .serial_out_pin_oe(sd_oe),
    .bclk_out(bco), .xmit_irq_ok(irqs[3]), .xmit_irq_exc(irqs[2]),
    .rcv_irq_ok(irqs[1]), .rcv_irq_exc(irqs[0])
  );

  ssc_codec ssc_codec_i (.tx_d(sd), .tx_oe(sd_oe), .pins(pins));

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    rd_reg(a);
    chk(nm, e, rd);
  endtask

  task automatic t_reset;
    rdc(ADDR_CTRL, 32'h0, "ctrl reset");
    rdc(ADDR_STAT, 32'h40, "stat reset");
    chk("irq reset", 32'h0, 32'(irqs));
    rd_reg(8'h18);
    chk("rd unmapped", 32'h3, 32'(rs));
    wr(8'h1c, 32'h1);
    chk("wr unmapped", 32'h3, 32'(rs));
  endtask

  task automatic t_ctrl;
    logic b0;
    wr(ADDR_CTRL, 32'hffff_0c00);
    rdc(ADDR_CTRL, 32'h0c00, "ctrl rw");
    cyc(8);
    chk("bclk gated", 32'h0, 32'(bco));
    wr(ADDR_STAT, 32'hff);
    rdc(ADDR_STAT, 32'h40, "stat ro");
    chk("bclk still", 32'h0, 32'(bco));
    wr(ADDR_CTRL, 32'h0);
    b0 = bco;
    cyc(4);
    chk("bclk runs", 32'(!b0), 32'(bco));
  endtask

  task automatic t_txirq;
    wr(ADDR_CTRL, 32'h4000);
    cyc(3);
    chk("tx irq", 32'h8, 32'(irqs));
    wr(ADDR_XMIT, 32'ha5);
    cyc(3);
    chk("tx irq gone", 32'h0, 32'(irqs));
  endtask

  task automatic t_frames;
    wr(ADDR_CTRL, 32'hf300);
    ssc_codec_i.frame(8'h3c, 1'b1, 1'b0);
    cyc(10);
    chk("tx word", 32'ha5, 32'(ssc_codec_i.got));
    rdc(ADDR_STAT, 32'hcd, "stat f1");
    chk("irq f1", 32'ha, 32'(irqs));
    ssc_codec_i.frame(8'h55, 1'b0, 1'b1);
    cyc(10);
    chk("tx resend", 32'ha5, 32'(ssc_codec_i.got));
    rdc(ADDR_STAT, 32'hfd, "stat f2");
    chk("irq f2", 32'h5, 32'(irqs));
    rdc(ADDR_RCV, 32'h3c, "rcv kept");
    cyc(3);
    chk("irq read", 32'h4, 32'(irqs));
  endtask

  task automatic t_disabled;
    wr(ADDR_CTRL, 32'h0304);
    wr(ADDR_XMIT, 32'h77);
    ssc_codec_i.frame(8'h11, 1'b1, 1'b1);
    cyc(10);
    chk("oe off", 32'h0, 32'(ssc_codec_i.oe_seen));
    rdc(ADDR_STAT, 32'h0c, "stat off");
    wr(ADDR_CTRL, 32'h0300);
    rdc(ADDR_STAT, 32'h0d, "flag on");
  endtask

  task automatic t_port_rst;
    wr(ADDR_PRST, 32'h1);
    wr(ADDR_PRST, 32'h0);
    rdc(ADDR_STAT, 32'h40, "stat prst");
    rdc(ADDR_CTRL, 32'h0300, "ctrl kept");
    wr(ADDR_NULL, 32'h0);
    rdc(ADDR_STAT, 32'h00, "stat null");
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_ctrl();
    t_txirq();
    t_frames();
    t_disabled();
    t_port_rst();
    wrap_up();
  end
endmodule // tb
